/* verification/rtc_alarm_match_and_irq_bench.sv */
// self-checking bench for the alarm flag and interrupt block
module rtc_alarm_match_and_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // short test-output half period keeps the run brief
  localparam int HALF = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic sec_tick = 1'b0;
  logic on_backup = 1'b0;
  logic [7:0] cur_sec = 8'h00, cur_min = 8'h00, cur_hour = 8'h00;
  logic [7:0] cur_date = 8'h00, cur_month = 8'h00, paddr;
  logic psel, penable, pwrite, pready, pslverr, irq, pin, oe;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic rerr, ie, e1, e2, p;
  logic [4:0] md1, md2;
  logic [4:0][7:0] al1, al2, tv;
  logic [4:0] modes [7] = '{5'h1f, 5'h1e, 5'h1c, 5'h14, 5'h10, 5'h00, 5'h0b};
  int seed = 25298;
  int n_tests = 0;
  int mismatches = 0;
  int cyc = 0;
  int n;

  always #10 pclk = ~pclk;

  rtcal_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  rtcal_alarm #(.FT_HALF_CYC(HALF)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sec_tick(sec_tick), .cur_sec(cur_sec),
    .cur_min(cur_min), .cur_hour(cur_hour), .cur_date(cur_date),
    .cur_month(cur_month), .on_backup(on_backup), .irq(irq),
    .shared_irq_test_out_pin(pin), .shared_irq_test_out_pin_oe(oe));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    u_host.xfer(1'b1, i, d, rdat, rerr);
  endtask

  task automatic rd(input logic [5:0] i);
    u_host.xfer(1'b0, i, 8'h00, rdat, rerr);
  endtask

  task automatic prog(input logic [5:0] b, input logic [4:0] md,
    input logic [4:0][7:0] v);
    for (int i = 0; i < 5; i++)
      wr(b + 6'(i), {md[i], v[i][6:0]});
  endtask

  // one-cycle compare strobe; ends where the flag has settled
  task automatic tick();
    @(posedge pclk);
    {cur_month, cur_date, cur_hour, cur_min, cur_sec} <= tv;
    sec_tick <= 1'b1;
    @(posedge pclk);
    sec_tick <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask

  function automatic logic hit(input logic [4:0] md,
    input logic [4:0][7:0] a, input logic [4:0][7:0] c);
    logic [4:0] eq;
    for (int i = 0; i < 5; i++)
      eq[i] = a[i][6:0] == c[i][6:0];
    case (md)
      5'h1e: hit = eq[0];
      5'h1c: hit = &eq[1:0];
      5'h14: hit = &eq[2:0];
      5'h10: hit = &eq[3:0];
      5'h00: hit = &eq;
      default: hit = 1'b1;
    endcase
  endfunction

  // each field kept equal with even odds, so matches are frequent
  function automatic logic [4:0][7:0] jitter(input logic [4:0][7:0] v);
    for (int i = 0; i < 5; i++)
      jitter[i] = ($random(seed) % 2) ? v[i] : 8'($random(seed));
  endfunction

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({irq, pin, oe}, 3'b010);
    rd(rtcal_pkg::IDX_CTRL);
    check(rdat, 32'h00000002);
    // a write with lane 0 off must leave the register untouched
    u_host.strb = 4'he;
    wr(rtcal_pkg::IDX_CTRL, 8'h05);
    u_host.strb = 4'hf;
    rd(rtcal_pkg::IDX_CTRL);
    check(rdat, 32'h00000002);
    rd(rtcal_pkg::IDX_CFG);
    check(rdat, 32'h00000000);
    rd(6'h3f);
    check({rerr, pready}, 2'b11);
    // flags are set by matches only, a bus write must not reach them
    wr(rtcal_pkg::IDX_FLAGS, 8'h60);
    rd(rtcal_pkg::IDX_FLAGS);
    check(rdat, 32'h00000000);
    tv = 40'({$random(seed), $random(seed)});
    prog(rtcal_pkg::IDX_ALM2, 5'h1f, tv);
    tick();
    rd(rtcal_pkg::IDX_FLAGS);
    check(rdat[5], 1'b0);
    rd(rtcal_pkg::IDX_ALM2);
    check(rdat, {24'h000000, 1'b1, tv[0][6:0]});
    wr(rtcal_pkg::IDX_CFG, 8'h02);
    for (int k = 0; k < 24; k++)
    begin
      md1 = (k % 8 == 7) ? 5'($random(seed)) : modes[k % 8];
      md2 = modes[(k + 3) % 7];
      ie = 1'($random(seed));
      al1 = 40'({$random(seed), $random(seed)});
      al2 = jitter(al1);
      tv = jitter(al1);
      wr(rtcal_pkg::IDX_MASK, {1'b0, ie, 6'h00});
      prog(rtcal_pkg::IDX_ALM1, md1, al1);
      prog(rtcal_pkg::IDX_ALM2, md2, al2);
      tick();
      e1 = hit(md1, al1, tv);
      e2 = hit(md2, al2, tv);
      tv = jitter(al1);
      tick();
      e1 = e1 | hit(md1, al1, tv);
      e2 = e2 | hit(md2, al2, tv);
      check({irq, pin, oe}, {e1 & ie, ~(e1 & ie), e1 & ie});
      rd(rtcal_pkg::IDX_FLAGS);
      check(rdat, {25'h0, e1, e2, 5'h00});
      @(negedge pclk);
      check(irq, 1'b0);
      rd(rtcal_pkg::IDX_FLAGS);
      check(rdat, 32'h00000000);
    end
    u_host.disable_alarm(rtcal_pkg::IDX_ALM1);
    tv[3] = 8'h15;
    tick();
    rd(rtcal_pkg::IDX_FLAGS);
    check(rdat[6], 1'b0);
    wr(rtcal_pkg::IDX_MASK, 8'h40);
    prog(rtcal_pkg::IDX_ALM1, 5'h1f, tv);
    rd(rtcal_pkg::IDX_FLAGS);
    tick();
    check(irq, 1'b0);
    rd(rtcal_pkg::IDX_ALM1);
    repeat (3) @(negedge pclk);
    check(irq, 1'b1);
    rd(rtcal_pkg::IDX_FLAGS);
    check(rdat[6], 1'b1);
    @(posedge pclk);
    on_backup <= 1'b1;
    wr(rtcal_pkg::IDX_CTRL, 8'h02);
    repeat (4) @(posedge pclk);
    tick();
    check(irq, 1'b0);
    rd(rtcal_pkg::IDX_FLAGS);
    check(rdat[6], 1'b1);
    wr(rtcal_pkg::IDX_CTRL, 8'h0a);
    tick();
    check(irq, 1'b1);
    rd(rtcal_pkg::IDX_FLAGS);
    @(negedge pclk);
    check(irq, 1'b1);
    @(posedge pclk);
    on_backup <= 1'b0;
    repeat (4) @(negedge pclk);
    check(irq, 1'b1);
    rd(rtcal_pkg::IDX_FLAGS);
    @(negedge pclk);
    check(irq, 1'b0);
    wr(rtcal_pkg::IDX_CTRL, 8'h03);
    @(negedge pclk);
    for (int j = 0; j < 3; j++)
    begin
      p = pin;
      n = 0;
      do
      begin
        @(negedge pclk);
        n++;
      end
      while (pin === p && n < 100);
      if (j > 0)
        check(n, HALF);
    end
    wr(rtcal_pkg::IDX_CTRL, 8'h07);
    n = 0;
    repeat (3 * HALF)
    begin
      @(negedge pclk);
      n += (pin !== 1'b1);
    end
    check(n, 0);
    summarize();
  end
endmodule

/* verification/rtcal_host.sv */
// apb master model standing in for the host controller
module rtcal_host
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // byte strobes of the next transfer; the bench may drop lane 0
  logic [3:0] strb = 4'hf;

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end

  // request held unchanged until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [5:0] idx,
    input logic [7:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // zeroing the whole group clears the date byte and every repeat bit
  task automatic disable_alarm(input logic [5:0] base);
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 5; i++)
      xfer(1'b1, base + 6'(i), 8'h00, r, e);
  endtask
endmodule

/* verilog/rtcal_alarm.sv */
// alarm registers, flags, interrupt and test output of the clock, on apb

module rtcal_alarm
#(
  parameter int FT_HALF_CYC = rtcal_pkg::FT_HALF_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic sec_tick,
  input wire logic [7:0] cur_sec,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_date,
  input wire logic [7:0] cur_month,
  input wire logic on_backup,
  output logic irq,
  output logic shared_irq_test_out_pin,
  output logic shared_irq_test_out_pin_oe
);

  localparam int CW = $clog2(FT_HALF_CYC + 1);
  localparam logic [CW-1:0] FT_LAST = CW'(FT_HALF_CYC - 1);

  typedef struct packed {
    logic [9:0][7:0] alm;
    logic af1;
    logic af2;
    logic alarm2_enable;
    logic alarm1_irq_enable;
    logic [3:0] ctrl;
    logic [5:0] ptr;
    logic pend1;
    logic pend2;
    logic irq;
    logic [1:0] bkp_sync;
    logic [CW-1:0] ft_cnt;
    logic ft_lvl;
    logic [31:0] prdata;
    logic slverr;
  } rtcal_state_t;

  rtcal_state_t s_r;
  rtcal_state_t s_nxt;

  logic [5:0] idx;
  logic setup_ph;
  logic acc_ph;
  logic rd_flags;
  logic on_flags;
  logic backup;
  logic match1;
  logic match2;
  logic hit1;
  logic hit2;
  logic ev1;
  logic ev2;
  logic irq_set;
  logic ft_on;
  logic out_bit;
  logic [7:0] rbyte;

  rtcal_match u_match1
  (
    .alarm(s_r.alm[4:0]),
    .cur_sec(cur_sec),
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .cur_date(cur_date),
    .cur_month(cur_month),
    .hit(match1)
  );

  rtcal_match u_match2
  (
    .alarm(s_r.alm[9:5]),
    .cur_sec(cur_sec),
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .cur_date(cur_date),
    .cur_month(cur_month),
    .hit(match2)
  );

  // one wait-free access: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.slverr;
  assign idx = paddr[7:2];
  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable;
  assign rd_flags = acc_ph & ~pwrite & (idx == rtcal_pkg::IDX_FLAGS);
  assign on_flags = s_r.ptr == rtcal_pkg::IDX_FLAGS;
  assign backup = s_r.bkp_sync[1];
  assign out_bit = s_r.ctrl[rtcal_pkg::CTRL_OUT_BIT];
  // a zeroed date with year mode never matches, so no extra disable logic
  assign hit1 = sec_tick & match1;
  assign hit2 = sec_tick & match2 & s_r.alarm2_enable;
  // held matches fire once the pointer leaves the flags address
  assign ev1 = (hit1 | s_r.pend1) & ~on_flags;
  assign ev2 = (hit2 | s_r.pend2) & ~on_flags;
  // only alarm 1 reaches the pin; backup needs its own enable
  assign irq_set = ev1 & s_r.alarm1_irq_enable &
    (~backup | s_r.ctrl[rtcal_pkg::CTRL_ABE_BIT]);
  assign ft_on = s_r.ctrl[rtcal_pkg::CTRL_FT_BIT] & out_bit &
    ~s_r.ctrl[rtcal_pkg::CTRL_ST_BIT];

  // test toggle wins over the interrupt; open drain only pulls low
  assign shared_irq_test_out_pin = ft_on ? s_r.ft_lvl :
    (s_r.irq ? 1'b0 : out_bit);
  assign shared_irq_test_out_pin_oe = ~shared_irq_test_out_pin;
  assign irq = s_r.irq;

  always_comb
  begin
    case (idx)
      rtcal_pkg::IDX_FLAGS: rbyte = 8'h00 | ({7'h00, s_r.af1} <<
        rtcal_pkg::AF1_BIT) | ({7'h00, s_r.af2} << rtcal_pkg::AF2_BIT);
      rtcal_pkg::IDX_CFG: rbyte = {7'h00, s_r.alarm2_enable} << rtcal_pkg::ALARM2_ENABLE_BIT;
      rtcal_pkg::IDX_CTRL: rbyte = {4'h0, s_r.ctrl};
      rtcal_pkg::IDX_MASK: rbyte = {7'h00, s_r.alarm1_irq_enable} << rtcal_pkg::AF1_BIT;
      default:
      begin
        if (idx >= rtcal_pkg::IDX_ALM1 && idx < rtcal_pkg::IDX_FLAGS)
          rbyte = s_r.alm[4'(idx - rtcal_pkg::IDX_ALM1)];
        else if (idx >= rtcal_pkg::IDX_ALM2 && idx < rtcal_pkg::IDX_CTRL)
          rbyte = s_r.alm[4'(idx - rtcal_pkg::IDX_ALM2 + 6'd5)];
        else
          rbyte = 8'h00;
      end
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    // the supply flag comes from the power comparator, off this clock
    s_nxt.bkp_sync = {s_r.bkp_sync[0], on_backup};
    if (setup_ph)
    begin
      s_nxt.prdata = {24'h000000, rbyte};
      s_nxt.slverr = ~rtcal_pkg::is_mapped(idx);
    end
    if (acc_ph)
    begin
      s_nxt.ptr = idx;
      if (pwrite && pstrb[0])
      begin
        case (idx)
          rtcal_pkg::IDX_CFG: s_nxt.alarm2_enable = pwdata[rtcal_pkg::ALARM2_ENABLE_BIT];
          rtcal_pkg::IDX_CTRL: s_nxt.ctrl = pwdata[3:0];
          rtcal_pkg::IDX_MASK: s_nxt.alarm1_irq_enable = pwdata[rtcal_pkg::AF1_BIT];
          default:
          begin
            // alarm 2 bytes keep data as user storage when disabled
            if (idx >= rtcal_pkg::IDX_ALM1 && idx < rtcal_pkg::IDX_FLAGS)
              s_nxt.alm[4'(idx - rtcal_pkg::IDX_ALM1)] =
                pwdata[7:0];
            else if (idx >= rtcal_pkg::IDX_ALM2 && idx < rtcal_pkg::IDX_CTRL)
              s_nxt.alm[4'(idx - rtcal_pkg::IDX_ALM2 + 6'd5)] =
                pwdata[7:0];
          end
        endcase
      end
    end
    s_nxt.pend1 = (s_r.pend1 | hit1) & on_flags;
    s_nxt.pend2 = (s_r.pend2 | hit2) & on_flags;
    // read data was latched before the clear; a new match wins over it
    if (rd_flags)
    begin
      s_nxt.af1 = 1'b0;
      s_nxt.af2 = 1'b0;
    end
    if (ev1)
      s_nxt.af1 = 1'b1;
    if (ev2)
      s_nxt.af2 = 1'b1;
    // in backup a flags read clears the flags but not the interrupt, so the pin holds until a flags read after supply is back
    if (rd_flags && !backup)
      s_nxt.irq = 1'b0;
    if (irq_set)
      s_nxt.irq = 1'b1;
    // divider runs off the bus clock, no calibration term enters it
    if (ft_on)
    begin
      if (s_r.ft_cnt == FT_LAST)
      begin
        s_nxt.ft_cnt = '0;
        s_nxt.ft_lvl = ~s_r.ft_lvl;
      end
      else
        s_nxt.ft_cnt = s_r.ft_cnt + CW'(1);
    end
    else
    begin
      s_nxt.ft_cnt = '0;
      s_nxt.ft_lvl = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.alm <= {10{rtcal_pkg::ALM_RESET}};
      s_r.ctrl <= rtcal_pkg::CTRL_RESET;
      s_r.alarm2_enable <= rtcal_pkg::ALARM2_ENABLE_RESET;
      s_r.alarm1_irq_enable <= rtcal_pkg::ALARM1_IRQ_ENABLE_RESET;
    end
    else
      s_r <= s_nxt;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_flags_setup;
    setup_ph && idx == rtcal_pkg::IDX_FLAGS && !pwrite;
  endsequence

  sequence s_flags_access;
    acc_ph && !pwrite && idx == rtcal_pkg::IDX_FLAGS;
  endsequence

  property p_af1_set;
    ev1 |=> s_r.af1;
  endproperty
  a_af1_set: assert property (p_af1_set)
    else $error("alarm 1 match did not set its flag");

  property p_flag_deferred;
    on_flags && hit1 && !s_r.af1 && !(acc_ph && idx != rtcal_pkg::IDX_FLAGS)
      |=> !s_r.af1 ##1 (s_r.pend1 || s_r.af1 || !on_flags);
  endproperty
  a_flag_deferred: assert property (p_flag_deferred)
    else $error("flag set while pointer rests on flags");

  property p_pend_release;
    s_r.pend1 && !on_flags |=> s_r.af1;
  endproperty
  a_pend_release: assert property (p_pend_release)
    else $error("held alarm not released after pointer moved");

  property p_read_returns_set;
    (s_flags_setup and s_r.af1) ##1 s_flags_access |->
      s_r.prdata[rtcal_pkg::AF1_BIT];
  endproperty
  a_read_returns_set: assert property (p_read_returns_set)
    else $error("flags read lost the set alarm flag");

  property p_read_clears;
    s_flags_access and !ev1 |=> !s_r.af1;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("flags read left alarm flag set");

  property p_irq_release;
    rd_flags && !backup && !irq_set |=> !s_r.irq ##0 shared_irq_test_out_pin
      || ft_on || !out_bit;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("flags read did not release the interrupt");

  property p_backup_hold;
    s_r.irq && backup |=> s_r.irq;
  endproperty
  a_backup_hold: assert property (p_backup_hold)
    else $error("backup interrupt dropped before supply returned");

  property p_backup_gate;
    ev1 && backup && !s_r.ctrl[rtcal_pkg::CTRL_ABE_BIT] && !s_r.irq
      |=> !s_r.irq;
  endproperty
  a_backup_gate: assert property (p_backup_gate)
    else $error("interrupt raised in backup without enable");

  property p_pin_low;
    ev1 && s_r.alarm1_irq_enable && !backup |=> (!ft_on) |-> !shared_irq_test_out_pin;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("enabled alarm 1 match did not pull the pin low");

  property p_ft_toggle;
    ft_on && s_r.ft_cnt == FT_LAST ##1 ft_on |->
      s_r.ft_lvl != $past(s_r.ft_lvl);
  endproperty
  a_ft_toggle: assert property (p_ft_toggle)
    else $error("test output failed to toggle at half period");

  property p_alarm2_enable_off;
    !s_r.alarm2_enable && !s_r.pend2 && !s_r.af2 && !rd_flags |=> !s_r.af2;
  endproperty
  a_alarm2_enable_off: assert property (p_alarm2_enable_off)
    else $error("alarm 2 flag set while alarm 2 disabled");

  property p_af2_no_irq;
    ev2 && !ev1 && !s_r.irq |=> !s_r.irq;
  endproperty
  a_af2_no_irq: assert property (p_af2_no_irq)
    else $error("alarm 2 raised the interrupt");

  property p_sticky;
    s_r.af1 && !rd_flags |=> s_r.af1;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("alarm 1 flag dropped without a flags read");

  property p_ft_hold;
    ft_on && s_r.ft_cnt != FT_LAST ##1 ft_on |-> $stable(s_r.ft_lvl);
  endproperty
  a_ft_hold: assert property (p_ft_hold)
    else $error("test output changed before its half period");

  property p_af2_clear;
    rd_flags && !ev2 |=> !s_r.af2;
  endproperty
  a_af2_clear: assert property (p_af2_clear)
    else $error("flags read left alarm 2 flag set");

endmodule

/* verilog/rtcal_match.sv */
// alarm comparator: repeat-mode decode and field compare for one group
module rtcal_match
(
  input wire logic [39:0] alarm,
  input wire logic [7:0] cur_sec,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_date,
  input wire logic [7:0] cur_month,
  output logic hit
);

  logic [4:0] rpt;
  logic [4:0] use_field;
  logic [4:0] eq;

  always_comb
  begin
    rpt = {alarm[8*rtcal_pkg::BYTE_MONTH + rtcal_pkg::RPT_BIT],
           alarm[8*rtcal_pkg::BYTE_DATE + rtcal_pkg::RPT_BIT],
           alarm[8*rtcal_pkg::BYTE_HOUR + rtcal_pkg::RPT_BIT],
           alarm[8*rtcal_pkg::BYTE_MIN + rtcal_pkg::RPT_BIT],
           alarm[8*rtcal_pkg::BYTE_SEC + rtcal_pkg::RPT_BIT]};
    // fields that take part: month, date, hour, minute, second
    case (rpt)
      rtcal_pkg::RPT_MINUTE: use_field = 5'h01;
      rtcal_pkg::RPT_HOUR: use_field = 5'h03;
      rtcal_pkg::RPT_DAY: use_field = 5'h07;
      rtcal_pkg::RPT_MONTH: use_field = 5'h0f;
      rtcal_pkg::RPT_YEAR: use_field = 5'h1f;
      // odd codes fire every second so a bad setup shows quickly
      default: use_field = 5'h00;
    endcase
    eq[0] = alarm[6:0] == cur_sec[6:0];
    eq[1] = alarm[14:8] == cur_min[6:0];
    eq[2] = alarm[22:16] == cur_hour[6:0];
    eq[3] = alarm[30:24] == cur_date[6:0];
    eq[4] = alarm[38:32] == cur_month[6:0];
    hit = &(eq | ~use_field);
  end

endmodule

/* verilog/rtcal_pkg.sv */
// package: register map, field positions and timing for the alarm block
package rtcal_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_ALM1 = 6'h0a;
  localparam logic [5:0] IDX_FLAGS = 6'h0f;
  localparam logic [5:0] IDX_CFG = 6'h13;
  localparam logic [5:0] IDX_ALM2 = 6'h14;
  localparam logic [5:0] IDX_CTRL = 6'h19;
  localparam logic [5:0] IDX_MASK = 6'h1a;
  localparam int ALM_BYTES = 5;

  // alarm byte order inside a group, repeat bit sits in bit 7 of each
  localparam int BYTE_SEC = 0;
  localparam int BYTE_MIN = 1;
  localparam int BYTE_HOUR = 2;
  localparam int BYTE_DATE = 3;
  localparam int BYTE_MONTH = 4;
  localparam int RPT_BIT = 7;

  // flags and mask share the alarm 1 flag bit, alarm 2 has a flag bit only; the alarm 2 enable bit sits in the config register
  localparam int AF1_BIT = 6;
  localparam int AF2_BIT = 5;
  localparam int ALARM2_ENABLE_BIT = 1;

  // control register fields
  localparam int CTRL_FT_BIT = 0;
  localparam int CTRL_OUT_BIT = 1;
  localparam int CTRL_ST_BIT = 2;
  localparam int CTRL_ABE_BIT = 3;

  localparam logic [3:0] CTRL_RESET = 4'h2;
  localparam logic ALARM2_ENABLE_RESET = 1'b0;
  localparam logic ALARM1_IRQ_ENABLE_RESET = 1'b0;
  localparam logic [7:0] ALM_RESET = 8'h00;

  // repeat modes, fifth bit down to first
  localparam logic [4:0] RPT_SECOND = 5'h1f;
  localparam logic [4:0] RPT_MINUTE = 5'h1e;
  localparam logic [4:0] RPT_HOUR = 5'h1c;
  localparam logic [4:0] RPT_DAY = 5'h14;
  localparam logic [4:0] RPT_MONTH = 5'h10;
  localparam logic [4:0] RPT_YEAR = 5'h00;

  // frequency-test output timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int FT_HZ = 512;
  localparam int FT_HALF_CYC = 1000000000 / (CLK_PERIOD_NS * 2 * FT_HZ);

  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx >= IDX_ALM1 && idx <= IDX_FLAGS) || idx == IDX_CFG ||
      (idx >= IDX_ALM2 && idx <= IDX_MASK);
  endfunction

endpackage
